// file: src/uirq_top.sv
// UART interrupt priority encoder, receive trigger and line format with AXI4-Lite registers
// Behaviour
// - Table A receive triggers 1,4,8,14
// - Selector picks tables B, C or user D
// - Trigger interrupt rearms after refilling to level
// - Six prioritized levels, highest reported first
// - Source read clears only reported interrupt
// - Line status level one code 000110
// - Level two data ready 000100, timeout 001100
// - Holding empty level three code 000010
// - Modem status level four code 000000
// - Xoff or special character code 010000
// - CTS/RTS change lowest, code 100000
// - Bit zero low when any pending, Xoff and CTS/RTS only with enhanced enable
// - Bits four, five need enhanced enable
// - Xoff bit holds until Xon received
// - Bits six, seven mirror FIFO enable
// - Format bits 1:0 give 5-8 data bits
// - Unused upper received bits are zero
// - Stop bits 1, 1.5 or 2
// - Format bit seven maps divisor registers
// - Value BF opens enhanced register set
// - Line status read clears its interrupt
// - Source read clears transmitter empty interrupt
// - Modem status read clears its interrupt
//
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/10ps
`include "uirq_consts.svh"
module uirq_top (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Event pulses, FIFO fill level and raw byte from the surrounding UART
  input wire logic line_err_evt,
  input wire logic rx_timeout_evt,
  input wire logic tx_holding_empty_evt,
  input wire logic modem_chg_evt,
  input wire logic xoff_evt,
  input wire logic xon_evt,
  input wire logic ctsrts_evt,
  input wire logic [7:0] rx_fill_count,
  input wire logic [7:0] rx_raw_byte,
  // Line format outputs
  output logic [3:0] data_bits,
  output logic [1:0] stop_half_bits,
  output logic [7:0] rx_byte_masked,
  output logic rx_data_ready,
  output logic [7:0] divisor_high
);
  // Register state
  logic [7:0] line_format_reg_q;
  logic [7:0] fifo_setup_reg_q;
  logic [7:0] feature_select_reg_q;
  logic [7:0] enhanced_feature_reg_q;
  logic [7:0] divisor_low_q;
  logic [7:0] divisor_high_q;
  logic [7:0] user_trig_q;
  logic line_pend_q, rxto_pend_q, thr_pend_q, modem_pend_q, xoff_pend_q, cts_pend_q;
  logic trig_lvl_q;
  logic [7:0] trig_level;
  logic trig_hit;
  logic [5:0] src_code;
  logic [7:0] src_full;
  logic enh_set, dlab, fifo_en, enh_en;
  // Write channel state
  logic aw_got_q, w_got_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  // Read channel state
  uirq_pkg::uirq_rd_t rd_state_q;
  logic rd_take;
  logic [7:0] rd_addr;
  logic rd_src, rd_lstat, rd_mstat;
  logic [31:0] rd_word;
  logic rd_ok;

  // Mode decode from the format, FIFO setup and enhanced feature registers
  assign enh_set = (line_format_reg_q == `UIRQ_ENH_KEY);
  assign dlab = line_format_reg_q[`UIRQ_LFMT_DLAB_BIT] && !enh_set;
  assign fifo_en = fifo_setup_reg_q[`UIRQ_FSET_EN_BIT];
  assign enh_en = enhanced_feature_reg_q[`UIRQ_ENH_EN_BIT];

  // Receive trigger level from the selected table
  always_comb begin
    trig_level = 8'h01;
    case (uirq_pkg::uirq_tbl_t'(feature_select_reg_q[5:4]))
      uirq_pkg::UIRQ_TBL_A: begin
        case (fifo_setup_reg_q[7:6])
          2'b00: trig_level = 8'h01;
          2'b01: trig_level = 8'h04;
          2'b10: trig_level = 8'h08;
          default: trig_level = 8'h0e;
        endcase
      end
      uirq_pkg::UIRQ_TBL_B: begin
        case (fifo_setup_reg_q[7:6])
          2'b00: trig_level = 8'h08;
          2'b01: trig_level = 8'h08;
          2'b10: trig_level = 8'h18;
          default: trig_level = 8'h1c;
        endcase
      end
      uirq_pkg::UIRQ_TBL_C: begin
        case (fifo_setup_reg_q[7:6])
          2'b00: trig_level = 8'h08;
          2'b01: trig_level = 8'h10;
          2'b10: trig_level = 8'h38;
          default: trig_level = 8'h3c;
        endcase
      end
      default: trig_level = user_trig_q;
    endcase
  end

  // Level-sensitive trigger: clears below level, rearms on refill
  assign trig_hit = fifo_en ? (rx_fill_count >= trig_level) : (rx_fill_count != 8'h00);

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      trig_lvl_q <= 1'b0;
    end else begin
      trig_lvl_q <= trig_hit;
    end
  end

  // Priority encoder, highest level wins
  always_comb begin
    src_code = `UIRQ_SRC_IDLE;
    if (line_pend_q) begin
      src_code = `UIRQ_SRC_LINE;
    end else if (rxto_pend_q) begin
      src_code = `UIRQ_SRC_RXTO;
    end else if (trig_lvl_q) begin
      src_code = `UIRQ_SRC_RXDATA;
    end else if (thr_pend_q) begin
      src_code = `UIRQ_SRC_THR;
    end else if (modem_pend_q) begin
      src_code = `UIRQ_SRC_MODEM;
    end else if (xoff_pend_q && enh_en) begin
      src_code = `UIRQ_SRC_XOFF;
    end else if (cts_pend_q && enh_en) begin
      src_code = `UIRQ_SRC_CTSRTS;
    end
  end

  assign src_full = {fifo_en, fifo_en, src_code};

  // Read side decode
  assign rd_take = s_axi_arvalid && (rd_state_q == uirq_pkg::UIRQ_RD_IDLE);
  assign rd_addr = s_axi_araddr;
  assign rd_src = rd_take && (rd_addr == `UIRQ_OFF_SRC);
  assign rd_lstat = rd_take && (rd_addr == `UIRQ_OFF_LSRD);
  assign rd_mstat = rd_take && (rd_addr == `UIRQ_OFF_MSRD);

  // Pending flags: set wins over clear
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      line_pend_q <= 1'b0;
      rxto_pend_q <= 1'b0;
      thr_pend_q <= 1'b0;
      modem_pend_q <= 1'b0;
      xoff_pend_q <= 1'b0;
      cts_pend_q <= 1'b0;
    end else begin
      line_pend_q <= line_err_evt || (line_pend_q && !rd_lstat);
      // Timeout is cleared by the source read that reports it
      rxto_pend_q <= rx_timeout_evt ||
        (rxto_pend_q && !(rd_src && src_code == `UIRQ_SRC_RXTO));
      thr_pend_q <= tx_holding_empty_evt ||
        (thr_pend_q && !(rd_src && src_code == `UIRQ_SRC_THR));
      modem_pend_q <= modem_chg_evt || (modem_pend_q && !rd_mstat);
      xoff_pend_q <= xoff_evt || (xoff_pend_q && !xon_evt);
      cts_pend_q <= ctsrts_evt ||
        (cts_pend_q && !(rd_src && src_code == `UIRQ_SRC_CTSRTS));
    end
  end

  // Read data multiplexer
  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    case (rd_addr)
      `UIRQ_OFF_SRC: rd_word = {24'h000000, src_full};
      `UIRQ_OFF_LFMT: rd_word = {24'h000000, line_format_reg_q};
      `UIRQ_OFF_FSET: rd_word = {24'h000000, fifo_setup_reg_q};
      `UIRQ_OFF_FSEL: rd_word = {24'h000000, feature_select_reg_q};
      `UIRQ_OFF_ENH: rd_word = enh_set ? {24'h000000, enhanced_feature_reg_q} : 32'h0;
      `UIRQ_OFF_EVT: rd_word = {26'h0, cts_pend_q, xoff_pend_q, modem_pend_q,
                                thr_pend_q, rxto_pend_q, line_pend_q};
      `UIRQ_OFF_LSRD: rd_word = {31'h0, line_pend_q};
      `UIRQ_OFF_MSRD: rd_word = {31'h0, modem_pend_q};
      `UIRQ_OFF_RXCNT: rd_word = {24'h000000, rx_fill_count};
      `UIRQ_OFF_UTRIG: rd_word = {24'h000000, user_trig_q};
      `UIRQ_OFF_DLL: rd_word = dlab ? {24'h000000, divisor_low_q} : 32'h0;
      `UIRQ_OFF_DIVH: rd_word = dlab ? {24'h000000, divisor_high_q} : 32'h0;
      `UIRQ_OFF_FMT: rd_word = {26'h0, stop_half_bits, data_bits};
      default: rd_ok = 1'b0;
    endcase
  end

  // Read channel: one read at a time
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rd_state_q <= uirq_pkg::UIRQ_RD_IDLE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'b00;
      s_axi_arready <= 1'b0;
    end else begin
      s_axi_arready <= 1'b0;
      case (rd_state_q)
        uirq_pkg::UIRQ_RD_IDLE: begin
          if (s_axi_arvalid) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? 2'b00 : 2'b10;
            rd_state_q <= uirq_pkg::UIRQ_RD_RESP;
          end
        end
        uirq_pkg::UIRQ_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state_q <= uirq_pkg::UIRQ_RD_IDLE;
          end
        end
        default: rd_state_q <= uirq_pkg::UIRQ_RD_IDLE;
      endcase
    end
  end

  // Write address and data capture in either order
  assign do_write = aw_got_q && w_got_q && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      aw_got_q <= 1'b0;
      w_got_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      if (s_axi_awvalid && !aw_got_q && !s_axi_awready) begin
        s_axi_awready <= 1'b1;
        aw_got_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_got_q && !s_axi_wready) begin
        s_axi_wready <= 1'b1;
        w_got_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_got_q <= 1'b0;
        w_got_q <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'b00;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (aw_addr_q <= `UIRQ_OFF_FMT && aw_addr_q[1:0] == 2'b00) ? 2'b00 : 2'b10;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Register writes, low byte lane only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      line_format_reg_q <= `UIRQ_LFMT_RST;
      fifo_setup_reg_q <= 8'h00;
      feature_select_reg_q <= 8'h00;
      enhanced_feature_reg_q <= 8'h00;
      divisor_low_q <= 8'h00;
      divisor_high_q <= 8'h00;
      user_trig_q <= `UIRQ_UTRIG_RST;
    end else if (do_write && w_strb_q[0]) begin
      case (aw_addr_q)
        `UIRQ_OFF_LFMT: line_format_reg_q <= w_data_q[7:0];
        `UIRQ_OFF_FSET: begin
          // Other fields only take while the enable bit is written as one
          if (w_data_q[0]) begin
            fifo_setup_reg_q <= {w_data_q[7:3], 2'b00, 1'b1};
          end else begin
            fifo_setup_reg_q <= {fifo_setup_reg_q[7:1], 1'b0};
          end
        end
        `UIRQ_OFF_FSEL: feature_select_reg_q <= w_data_q[7:0];
        `UIRQ_OFF_ENH: if (enh_set) enhanced_feature_reg_q <= w_data_q[7:0];
        `UIRQ_OFF_UTRIG: user_trig_q <= w_data_q[7:0];
        `UIRQ_OFF_DLL: if (dlab) divisor_low_q <= w_data_q[7:0];
        `UIRQ_OFF_DIVH: if (dlab) divisor_high_q <= w_data_q[7:0];
        default: ;
      endcase
    end
  end

  // Line format outputs, registered
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      data_bits <= 4'h5;
      stop_half_bits <= 2'h2;
      rx_byte_masked <= 8'h00;
      rx_data_ready <= 1'b0;
      divisor_high <= 8'h00;
    end else begin
      data_bits <= 4'h5 + {2'b00, line_format_reg_q[1:0]};
      if (!line_format_reg_q[`UIRQ_LFMT_STOP_BIT]) begin
        stop_half_bits <= 2'h2;
      end else if (line_format_reg_q[1:0] == 2'b00) begin
        stop_half_bits <= 2'h3;
      end else begin
        stop_half_bits <= 2'h0;
      end
      rx_byte_masked <= rx_raw_byte & (8'hff >> (2'd3 - line_format_reg_q[1:0]));
      rx_data_ready <= trig_hit;
      divisor_high <= divisor_high_q;
    end
  end
endmodule

// file: include/uirq_consts.svh
// Register offsets, field positions, reset values and table constants
`ifndef UIRQ_CONSTS_SVH
`define UIRQ_CONSTS_SVH
`define UIRQ_OFF_SRC 8'h00
`define UIRQ_OFF_LFMT 8'h04
`define UIRQ_OFF_FSET 8'h08
`define UIRQ_OFF_FSEL 8'h0c
`define UIRQ_OFF_ENH 8'h10
`define UIRQ_OFF_EVT 8'h14
`define UIRQ_OFF_LSRD 8'h18
`define UIRQ_OFF_MSRD 8'h1c
`define UIRQ_OFF_RXCNT 8'h20
`define UIRQ_OFF_UTRIG 8'h24
`define UIRQ_OFF_DLL 8'h28
`define UIRQ_OFF_DIVH 8'h2c
`define UIRQ_OFF_FMT 8'h30
`define UIRQ_LFMT_RST 8'h00
`define UIRQ_SRC_IDLE 6'h01
`define UIRQ_SRC_LINE 6'h06
`define UIRQ_SRC_RXDATA 6'h04
`define UIRQ_SRC_RXTO 6'h0c
`define UIRQ_SRC_THR 6'h02
`define UIRQ_SRC_MODEM 6'h00
`define UIRQ_SRC_XOFF 6'h10
`define UIRQ_SRC_CTSRTS 6'h20
`define UIRQ_ENH_KEY 8'hbf
`define UIRQ_ENH_EN_BIT 4
`define UIRQ_FSET_EN_BIT 0
`define UIRQ_LFMT_DLAB_BIT 7
`define UIRQ_LFMT_STOP_BIT 2
`define UIRQ_UTRIG_RST 8'h01
`endif

// file: include/uirq_pkg.sv
// Types shared by the interrupt priority and line format block
package uirq_pkg;
  typedef enum logic [1:0] {
    UIRQ_RD_IDLE = 2'b01,
    UIRQ_RD_RESP = 2'b10
  } uirq_rd_t;
  typedef enum logic [1:0] {
    UIRQ_TBL_A = 2'b00,
    UIRQ_TBL_B = 2'b01,
    UIRQ_TBL_C = 2'b10,
    UIRQ_TBL_D = 2'b11
  } uirq_tbl_t;
endpackage

// file: tb/uirq_top_properties.sv
// Concurrent checks on the bus, format and source register ports of the block
`timescale 1ns/10ps
module uirq_props (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Register bus
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic s_axi_awready,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // Line format
  input wire logic [3:0] data_bits,
  input wire logic [1:0] stop_half_bits,
  input wire logic [7:0] rx_byte_masked,
  input wire logic rx_data_ready
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Answer cycle of a source register read
  logic src_rd;
  assign src_rd = s_axi_arready && s_axi_rvalid && s_axi_araddr == 8'h00;
  a_read_answer: assert property (s_axi_arready |-> s_axi_rvalid)
    else $error("read answer missing");
  a_read_drop: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read answer stuck");
  a_write_resp: assert property (s_axi_awready && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer missing");
  a_resp_drop: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write answer stuck");
  a_word_length: assert property (data_bits >= 4'h5 && data_bits <= 4'h8)
    else $error("word length out of range");
  a_stop_length: assert property (stop_half_bits == 2'h3 |-> data_bits == 4'h5)
    else $error("half stop with long word");
  a_rx_upper_zero: assert property (data_bits == $past(data_bits) |->
    (rx_byte_masked >> data_bits) == 8'h00) else $error("upper bits not zero");
  a_src_idle_code: assert property (src_rd && s_axi_rdata[0] |->
    s_axi_rdata[5:1] == 5'h00) else $error("idle code wrong");
  a_src_fifo_bits: assert property (src_rd |-> s_axi_rdata[7] == s_axi_rdata[6]
    && s_axi_rdata[31:8] == 24'h0) else $error("fifo bits wrong");
  a_src_code_set: assert property (src_rd && !s_axi_rdata[0] |->
    s_axi_rdata[5:0] inside {6'h06, 6'h04, 6'h0c, 6'h02, 6'h00, 6'h10, 6'h20})
    else $error("bad source code");
  a_bad_addr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |->
    s_axi_rdata == 32'h0) else $error("error read data not zero");
  c_src_read: cover property (src_rd && !s_axi_rdata[0]);
  c_write_done: cover property (s_axi_bvalid && s_axi_bready);
  c_rx_ready: cover property ($rose(rx_data_ready));
endmodule
bind uirq_top uirq_props i_uirq_props (.ref_clk, .rst, .s_axi_araddr, .s_axi_arready,
  .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .s_axi_awready,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .data_bits, .stop_half_bits,
  .rx_byte_masked, .rx_data_ready);

// file: tb/uirq_far_model.sv
// Far-side receiver stand-in: event pulses, FIFO fill level and raw byte
`timescale 1ns/10ps
module uirq_far_model (
  // Clock
  input wire logic ref_clk,
  // Bench requests
  input wire logic [6:0] evt_req,
  input wire logic [7:0] fill_req,
  input wire logic [7:0] raw_req,
  // Toward the block
  output logic [6:0] evt_pulse = 7'h00,
  output logic [7:0] rx_fill_count = 8'h00,
  output logic [7:0] rx_raw_byte = 8'h00
);
  // Launch after the edge, one cycle per request, as a receiver would
  always_ff @(posedge ref_clk) begin
    evt_pulse <= evt_req;
    rx_fill_count <= fill_req;
    rx_raw_byte <= raw_req;
  end
endmodule

// file: tb/uirq_top_bench.sv
// Register-level bench for the interrupt priority and line format block
`timescale 1ns/10ps
`include "uirq_consts.svh"
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module uirq_top_bench;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, stop_half_bits, rr, br;
  logic [3:0] data_bits;
  logic [7:0] rx_fill_count, rx_raw_byte, rx_byte_masked, divisor_high;
  logic rx_data_ready;
  logic [6:0] evt_req = 7'h00, ev;
  logic [7:0] fill_req = 8'h00, raw_req = 8'hff;
  int errors = 0, checks = 0, cyc = 0;
  int lv[3][4] = '{'{1, 4, 8, 14}, '{8, 8, 24, 28}, '{8, 16, 56, 60}};
  uirq_top i_uirq_top (.ref_clk, .rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb(4'hf), .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .line_err_evt(ev[0]),
    .rx_timeout_evt(ev[1]), .tx_holding_empty_evt(ev[2]), .modem_chg_evt(ev[3]),
    .xoff_evt(ev[4]), .xon_evt(ev[5]), .ctsrts_evt(ev[6]), .rx_fill_count,
    .rx_raw_byte, .data_bits, .stop_half_bits, .rx_byte_masked, .rx_data_ready,
    .divisor_high);
  uirq_far_model i_uirq_far_model (.ref_clk, .evt_req, .fill_req, .raw_req,
    .evt_pulse(ev), .rx_fill_count, .rx_raw_byte);
  // Clock at 250 MHz
  initial begin
    forever #2 ref_clk = ~ref_clk;
  end
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 5000) begin
      errors++;
      report_and_stop();
    end
  end
  // Bus write: address and data offered together, each dropped when taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw = 1'b0;
    logic w = 1'b0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge ref_clk);
      if (s_axi_awready) begin
        aw = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wready) begin
        w = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!s_axi_bvalid) @(posedge ref_clk);
    br = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  // Bus read: answer taken at the edge where rvalid is seen
  task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    rdr(a, rd, rr);
    `CHK(rd, e)
  endtask
  // One-cycle event burst from the far side
  task automatic pulse(input logic [6:0] m);
    @(posedge ref_clk);
    evt_req <= m;
    @(posedge ref_clk);
    evt_req <= 7'h00;
  endtask
  task automatic fill(input int n);
    @(posedge ref_clk);
    fill_req <= n[7:0];
    repeat (3) @(posedge ref_clk);
  endtask
  // Just below, then at the level, twice over to see the trigger rearm
  task automatic trig(input int n);
    for (int k = 0; k < 2; k++) begin
      fill(n - 1);
      `CHK(rx_data_ready, 1'b0)
      fill(n);
      `CHK(rx_data_ready, 1'b1)
    end
  endtask
  task automatic report_and_stop();
    if (errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (3) @(posedge ref_clk);
    rst <= 1'b0;
    `CHK(data_bits, 4'h5)
    `CHK(stop_half_bits, 2'h2)
    rchk(`UIRQ_OFF_SRC, 32'h01);
    rchk(`UIRQ_OFF_LFMT, 32'h00);
    rdr(8'h3c, rd, rr);
    `CHK({rr, rd}, {2'b10, 32'h0})
    wr(8'h3c, 32'h0);
    `CHK(br, 2'b10)
    for (int i = 0; i < 8; i++) begin
      wr(`UIRQ_OFF_LFMT, i);
      `CHK(br, 2'b00)
      repeat (2) @(posedge ref_clk);
      `CHK(data_bits, 4'h5 + i[1:0])
      `CHK(stop_half_bits, !i[2] ? 2'h2 : i[1:0] == 2'h0 ? 2'h3 : 2'h0)
      `CHK(rx_byte_masked, 8'(8'hff >> (3 - i[1:0])))
    end
    wr(`UIRQ_OFF_LFMT, 32'h83);
    wr(`UIRQ_OFF_DIVH, 32'h5a);
    rchk(`UIRQ_OFF_DIVH, 32'h5a);
    wr(`UIRQ_OFF_LFMT, 32'h03);
    wr(`UIRQ_OFF_DIVH, 32'ha5);
    rchk(`UIRQ_OFF_DIVH, 32'h00);
    `CHK(divisor_high, 8'h5a)
    // Xoff and CTS/RTS sources stay hidden until the enhanced enable is set
    pulse(7'h50);
    rchk(`UIRQ_OFF_SRC, 32'h01);
    wr(`UIRQ_OFF_LFMT, 32'hbf);
    wr(`UIRQ_OFF_ENH, 32'h10);
    rchk(`UIRQ_OFF_ENH, 32'h10);
    wr(`UIRQ_OFF_LFMT, 32'h03);
    pulse(7'h5f);
    rchk(`UIRQ_OFF_SRC, 32'h06);
    rchk(`UIRQ_OFF_SRC, 32'h06);
    rdr(`UIRQ_OFF_LSRD, rd, rr);
    rchk(`UIRQ_OFF_SRC, 32'h0c);
    rchk(`UIRQ_OFF_SRC, 32'h02);
    rchk(`UIRQ_OFF_SRC, 32'h00);
    rchk(`UIRQ_OFF_SRC, 32'h00);
    rdr(`UIRQ_OFF_MSRD, rd, rr);
    rchk(`UIRQ_OFF_SRC, 32'h10);
    rchk(`UIRQ_OFF_SRC, 32'h10);
    pulse(7'h20);
    rchk(`UIRQ_OFF_SRC, 32'h20);
    rchk(`UIRQ_OFF_SRC, 32'h01);
    wr(`UIRQ_OFF_FSET, 32'h01);
    rchk(`UIRQ_OFF_SRC, 32'hc1);
    wr(`UIRQ_OFF_UTRIG, 32'h05);
    for (int t = 0; t < 4; t++) begin
      wr(`UIRQ_OFF_FSEL, t << 4);
      for (int c = 0; c < 4; c++) begin
        wr(`UIRQ_OFF_FSET, {24'h0, c[1:0], 6'h01});
        trig(t == 3 ? 5 : lv[t][c]);
      end
    end
    rchk(`UIRQ_OFF_SRC, 32'hc4);
    report_and_stop();
  end
endmodule
